// [logic/tsa_pkg.sv]
// Purpose: shared constants and types of the thermal sensor alert control
// Assumes: one clock (mclk, 250 MHz), synchronous active-high reset
// Notes:   temperatures are signed 8-bit degrees
package tsa_pkg;
   localparam int unsigned TEMP_W = 8;
   // register map, plain port address
   localparam logic [2:0] ADDR_CFG    = 3'h0;
   localparam logic [2:0] ADDR_HI_THR = 3'h1;
   localparam logic [2:0] ADDR_LO_THR = 3'h2;
   localparam logic [2:0] ADDR_DIODE  = 3'h3;
   localparam logic [2:0] ADDR_LOCAL  = 3'h4;
   localparam logic [2:0] ADDR_STAT   = 3'h5;
   localparam logic [2:0] ADDR_IMASK  = 3'h6;
   localparam logic [2:0] ADDR_CMD    = 3'h7;
   // configuration fields
   localparam int unsigned CFG_MASK_BIT = 7;
   localparam int unsigned CFG_HALT_BIT = 6;
   localparam logic [7:0]  CFG_RESET    = 8'h00;
   localparam logic [7:0]  CFG_WR_MASK  = 8'hc0;
   localparam logic [7:0]  HI_THR_RESET = 8'h7f;
   localparam logic [7:0]  LO_THR_RESET = 8'h80;
   localparam logic [7:0]  IMASK_RESET  = 8'h00;
   // status bits
   localparam int unsigned ST_CONV_DONE = 0;
   localparam int unsigned ST_ALERT     = 1;
   localparam int unsigned ST_ONESHOT   = 2;
   localparam int unsigned ST_W         = 3;
   // conversion time
   localparam int unsigned CONV_TIME_NS = 1000;
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned CONV_CYCLES  = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      TSA_IDLE = 2'b00,
      TSA_CONV = 2'b01,
      TSA_DONE = 2'b11
   } tsa_state_t;

   typedef struct packed {
      logic [7:0] diode;
      logic [7:0] local_t;
   } tsa_temps_t;
endpackage

// [logic/tsa_ctrl.sv]
// Purpose: alert and conversion control of a thermal sensor
// Assumes: raw temperature inputs are asynchronous and pass two flip-flops
// Notes:   out-of-window alert, auto/standby conversion, interrupt status
// Summary of operation
// - alert when either temperature leaves threshold window
// - equal to threshold may alert; we do not
// - halt bit six resets zero, auto-convert
// - halt set stops auto conversion at once, standby
// - one-shot command converts while in standby
// - mask bit seven resets zero, blocks alert pin, not alert status
`timescale 1ns/1ns
`default_nettype none
module tsa_ctrl
#(
   parameter int unsigned CONV_CYC = tsa_pkg::CONV_CYCLES
)
(
   input  wire logic                mclk,
   input  wire logic                sys_rst,
   input  wire tsa_pkg::tsa_temps_t temps_raw,
   input  wire logic [2:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [7:0]               reg_rdata,
   output logic                     smb_alert_n,
   output logic                     irq,
   output logic                     standby
);
   tsa_pkg::tsa_temps_t temps_s1_reg;
   tsa_pkg::tsa_temps_t temps_s2_reg;
   tsa_pkg::tsa_temps_t result_reg;
   tsa_pkg::tsa_state_t state_reg;
   logic [7:0]          cfg_reg;
   logic [7:0]          hi_reg;
   logic [7:0]          lo_reg;
   logic [7:0]          imask_reg;
   logic [tsa_pkg::ST_W-1:0] stat_reg;
   logic [15:0]         cnt_reg;
   logic                oneshot_req_reg;
   logic                out_win;
   logic                halt;
   logic                wr_cmd;
   logic                done_pulse;
   logic                alert_rise;
   logic                alert_q_reg;
   logic                shot_run_reg;

   assign halt   = cfg_reg[tsa_pkg::CFG_HALT_BIT];
   assign wr_cmd = reg_wr && (reg_addr == tsa_pkg::ADDR_CMD);

   // two-stage synchroniser for the analog front end outputs
   always_ff @(posedge mclk)
   begin
      temps_s1_reg <= temps_raw;
      temps_s2_reg <= temps_s1_reg;
   end

   // configuration: reserved bits are held at zero whatever is written
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         cfg_reg   <= tsa_pkg::CFG_RESET;
         hi_reg    <= tsa_pkg::HI_THR_RESET;
         lo_reg    <= tsa_pkg::LO_THR_RESET;
         imask_reg <= tsa_pkg::IMASK_RESET;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            tsa_pkg::ADDR_CFG:    cfg_reg <= reg_wdata & tsa_pkg::CFG_WR_MASK;
            tsa_pkg::ADDR_HI_THR: hi_reg <= reg_wdata;
            tsa_pkg::ADDR_LO_THR: lo_reg <= reg_wdata;
            tsa_pkg::ADDR_IMASK:  imask_reg <= reg_wdata;
            default:              ;
         endcase
      end
   end

   // one-shot request: held until the converter next reaches idle, taken there only in standby
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         oneshot_req_reg <= 1'b0;
      else if (wr_cmd)
         oneshot_req_reg <= 1'b1;
      else if (state_reg == tsa_pkg::TSA_IDLE)
         oneshot_req_reg <= 1'b0;
   end

   // converter: auto mode restarts forever, standby waits for one-shot
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         state_reg <= tsa_pkg::TSA_IDLE;
         cnt_reg   <= 16'h0000;
      end
      else
      begin
         case (state_reg)
            tsa_pkg::TSA_IDLE:
            begin
               if (!halt || oneshot_req_reg)
               begin
                  state_reg <= tsa_pkg::TSA_CONV;
                  cnt_reg   <= 16'h0000;
               end
            end
            tsa_pkg::TSA_CONV:
            begin
               // a halt write aborts auto conversion immediately
               if (halt && !shot_run_reg)
                  state_reg <= tsa_pkg::TSA_IDLE;
               else if (cnt_reg == 16'(CONV_CYC - 1))
                  state_reg <= tsa_pkg::TSA_DONE;
               else
                  cnt_reg <= cnt_reg + 16'h0001;
            end
            tsa_pkg::TSA_DONE:
               state_reg <= tsa_pkg::TSA_IDLE;
            default:
               state_reg <= tsa_pkg::TSA_IDLE;
         endcase
      end
   end

   assign done_pulse = (state_reg == tsa_pkg::TSA_DONE);

   // result latch on completion; standby result stays until next
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         result_reg <= '0;
      else if (done_pulse)
         result_reg <= temps_s2_reg;
   end

   // strict compare: equality never alerts, simplest legal choice
   assign out_win = ($signed(result_reg.diode) > $signed(hi_reg))
                 || ($signed(result_reg.diode) < $signed(lo_reg))
                 || ($signed(result_reg.local_t) > $signed(hi_reg))
                 || ($signed(result_reg.local_t) < $signed(lo_reg));

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         smb_alert_n <= 1'b1;
         alert_q_reg <= 1'b0;
      end
      else
      begin
         smb_alert_n <= !(out_win && !cfg_reg[tsa_pkg::CFG_MASK_BIT]);
         alert_q_reg <= out_win;
      end
   end

   assign alert_rise = out_win && !alert_q_reg;

   // sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         stat_reg <= '0;
      else
      begin
         for (int i = 0; i < int'(tsa_pkg::ST_W); i++)
         begin
            if ((i == tsa_pkg::ST_CONV_DONE && done_pulse)
                || (i == tsa_pkg::ST_ALERT && alert_rise)
                || (i == tsa_pkg::ST_ONESHOT && done_pulse && shot_run_reg))
               stat_reg[i] <= 1'b1;
            else if (reg_wr && reg_addr == tsa_pkg::ADDR_STAT && reg_wdata[i])
               stat_reg[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         irq     <= 1'b0;
         standby <= 1'b0;
      end
      else
      begin
         irq     <= |(stat_reg & imask_reg[tsa_pkg::ST_W-1:0]);
         standby <= halt && (state_reg == tsa_pkg::TSA_IDLE);
      end
   end

   // read port, data in the cycle after the strobe only
   always_ff @(posedge mclk)
   begin
      if (sys_rst || !reg_rd)
         reg_rdata <= 8'h00;
      else
      begin
         case (reg_addr)
            tsa_pkg::ADDR_CFG:    reg_rdata <= cfg_reg;
            tsa_pkg::ADDR_HI_THR: reg_rdata <= hi_reg;
            tsa_pkg::ADDR_LO_THR: reg_rdata <= lo_reg;
            tsa_pkg::ADDR_DIODE:  reg_rdata <= result_reg.diode;
            tsa_pkg::ADDR_LOCAL:  reg_rdata <= result_reg.local_t;
            tsa_pkg::ADDR_STAT:   reg_rdata <= {5'h00, stat_reg};
            tsa_pkg::ADDR_IMASK:  reg_rdata <= imask_reg;
            default:              reg_rdata <= 8'h00;
         endcase
      end
   end

   // a one-shot conversion survives the halt bit; an auto conversion does not
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         shot_run_reg <= 1'b0;
      else if (state_reg == tsa_pkg::TSA_IDLE)
         shot_run_reg <= halt && oneshot_req_reg;
   end

   // checks are gathered after all the logic they guard; covers mark the main scenarios
   AST_ALERT_OUT: assert property (@(posedge mclk) disable iff (sys_rst)
      ##1 smb_alert_n == !($past(out_win) && !$past(cfg_reg[tsa_pkg::CFG_MASK_BIT])))
      else $error("alert pin disagrees with window");
   AST_MASK_BLOCKS: assert property (@(posedge mclk) disable iff (sys_rst)
      cfg_reg[tsa_pkg::CFG_MASK_BIT] |=> smb_alert_n)
      else $error("masked alert asserted");
   AST_EQ_NO_ALERT: assert property (@(posedge mclk) disable iff (sys_rst)
      ($signed(result_reg.diode) <= $signed(hi_reg)
      && $signed(result_reg.diode) >= $signed(lo_reg)
      && $signed(result_reg.local_t) <= $signed(hi_reg)
      && $signed(result_reg.local_t) >= $signed(lo_reg)) |=> smb_alert_n)
      else $error("in-window reading alerted");
   AST_AUTO_RUNS: assert property (@(posedge mclk) disable iff (sys_rst)
      (!halt && state_reg == tsa_pkg::TSA_IDLE) |=> state_reg == tsa_pkg::TSA_CONV)
      else $error("auto mode idle");
   AST_RSV_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
      cfg_reg[5:0] == 6'h00)
      else $error("reserved bits set");
   AST_ONESHOT: assert property (@(posedge mclk) disable iff (sys_rst)
      (halt && oneshot_req_reg && state_reg == tsa_pkg::TSA_IDLE)
      |=> state_reg == tsa_pkg::TSA_CONV)
      else $error("one-shot ignored");
   AST_STAY_STANDBY: assert property (@(posedge mclk) disable iff (sys_rst)
      ((done_pulse || state_reg == tsa_pkg::TSA_IDLE) && halt && !oneshot_req_reg)
      |=> state_reg == tsa_pkg::TSA_IDLE)
      else $error("left standby");
   AST_STANDBY_OUT: assert property (@(posedge mclk) disable iff (sys_rst)
      (halt && state_reg == tsa_pkg::TSA_IDLE) |=> standby)
      else $error("standby flag missing");
   AST_HALT_STOPS: assert property (@(posedge mclk) disable iff (sys_rst)
      (halt && !shot_run_reg && state_reg == tsa_pkg::TSA_CONV)
      |=> state_reg == tsa_pkg::TSA_IDLE)
      else $error("conversion ran on after halt");
   AST_SHOT_RUNS: assert property (@(posedge mclk) disable iff (sys_rst)
      (shot_run_reg && state_reg == tsa_pkg::TSA_CONV)
      |=> state_reg != tsa_pkg::TSA_IDLE)
      else $error("one-shot conversion cut short");
   AST_RESULT_TAKE: assert property (@(posedge mclk) disable iff (sys_rst)
      done_pulse |=> result_reg == $past(temps_s2_reg))
      else $error("result not updated");
   AST_RESULT_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
      !done_pulse |=> $stable(result_reg))
      else $error("result changed without conversion");
   AST_STANDBY_LOW: assert property (@(posedge mclk) disable iff (sys_rst)
      !halt |=> !standby)
      else $error("standby shown in auto mode");
   AST_ALERT_STAT: assert property (@(posedge mclk) disable iff (sys_rst)
      alert_rise |=> stat_reg[tsa_pkg::ST_ALERT])
      else $error("alert event not recorded");
   AST_STAT_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst)
      (reg_wr && reg_addr == tsa_pkg::ADDR_STAT && reg_wdata[tsa_pkg::ST_ALERT] && !alert_rise)
      |=> !stat_reg[tsa_pkg::ST_ALERT])
      else $error("alert status not cleared");
   AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (sys_rst)
      ##1 irq == (|$past(stat_reg & imask_reg[tsa_pkg::ST_W-1:0])))
      else $error("interrupt level wrong");
   AST_CFG_READ: assert property (@(posedge mclk) disable iff (sys_rst)
      (reg_rd && reg_addr == tsa_pkg::ADDR_CFG) |=> reg_rdata[5:0] == 6'h00)
      else $error("reserved bits read back set");
   AST_CONV_CNT: assert property (@(posedge mclk) disable iff (sys_rst)
      state_reg == tsa_pkg::TSA_CONV |-> cnt_reg < 16'(CONV_CYC))
      else $error("conversion counter overran");
   AST_DONE_ONE: assert property (@(posedge mclk) disable iff (sys_rst)
      done_pulse |=> !done_pulse)
      else $error("completion lasted more than one cycle");
   AST_ONESHOT_STAT: assert property (@(posedge mclk) disable iff (sys_rst)
      (done_pulse && shot_run_reg) |=> stat_reg[tsa_pkg::ST_ONESHOT])
      else $error("one-shot completion not recorded");
   COV_ALERT: cover property (@(posedge mclk) disable iff (sys_rst) !smb_alert_n);
   COV_ONESHOT: cover property (@(posedge mclk) disable iff (sys_rst) done_pulse && shot_run_reg);
   COV_IRQ: cover property (@(posedge mclk) disable iff (sys_rst) irq);
   COV_HALT_ABORT: cover property (@(posedge mclk) disable iff (sys_rst) halt && !shot_run_reg && state_reg == tsa_pkg::TSA_CONV);
   COV_EQUAL: cover property (@(posedge mclk) disable iff (sys_rst) result_reg.diode == hi_reg);
endmodule
`default_nettype wire

// [verif/tsa_host.sv]
// Purpose: register-port host model for the thermal alert block
// Assumes: one clock, strobes launched by non-blocking assignment after a rising edge
// Notes:   idle address and data are inverted so a stale value is never reused
`timescale 1ns/1ns
`default_nettype none
module tsa_host
(
   input  wire logic       mclk,
   output logic [2:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   initial
   begin
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // callers send reserved bits as zero except in the refusal case
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask
   // data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// [verif/test_thermal_sensor_alert_control.sv]
// Purpose: self-checking bench of the thermal alert block
// Assumes: short conversion count so a run stays brief
// Notes:   one-shot is only issued in standby, monitoring uses auto mode
`timescale 1ns/1ns
`default_nettype none
module test_thermal_sensor_alert_control;
   localparam int unsigned CC = 4;
   logic                mclk;
   logic                sys_rst;
   tsa_pkg::tsa_temps_t temps;
   logic [2:0]          reg_addr;
   logic [7:0]          reg_wdata;
   logic                reg_wr;
   logic                reg_rd;
   logic [7:0]          reg_rdata;
   logic                smb_alert_n;
   logic                irq;
   logic                standby;
   logic [7:0]          rv;
   logic [7:0]          hi;
   logic [7:0]          lo;
   logic [7:0]          d;
   int                  errors;
   int                  total_checks;
   int                  seed;
   tsa_host i_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   tsa_ctrl #(.CONV_CYC(CC)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
      .temps_raw(temps), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smb_alert_n(smb_alert_n), .irq(irq),
      .standby(standby));
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic wrap_up();
      if (errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
      i_host.rd(a, rv);
      chk(rv, e);
   endtask
   // equality with a threshold is allowed to stay quiet, the design chose so
   function automatic logic exp_alert(input logic [7:0] t1, input logic [7:0] t2,
      input logic m);
      return !m && ($signed(t1) > $signed(hi) || $signed(t1) < $signed(lo) ||
         $signed(t2) > $signed(hi) || $signed(t2) < $signed(lo));
   endfunction
   // two sync flops plus two full conversions, with margin
   task automatic settle();
      repeat (4 * CC + 8) @(posedge mclk);
      #1;
   endtask
   task automatic apply(input logic [7:0] t1, input logic [7:0] t2, input logic m);
      @(posedge mclk);
      temps.diode   <= t1;
      temps.local_t <= t2;
      settle();
      chk({7'h00, smb_alert_n}, {7'h00, ~exp_alert(t1, t2, m)});
      rdchk(tsa_pkg::ADDR_DIODE, t1);
      rdchk(tsa_pkg::ADDR_LOCAL, t2);
   endtask
   initial
   begin
      #100000;
      errors++;
      wrap_up();
   end
   initial
   begin
      seed = 5;
      errors = 0;
      total_checks = 0;
      sys_rst = 1'b1;
      temps = '0;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      rdchk(tsa_pkg::ADDR_CFG, 8'h00);
      chk({6'h00, irq, smb_alert_n}, 8'h01);
      i_host.wr(tsa_pkg::ADDR_CFG, 8'hff);
      rdchk(tsa_pkg::ADDR_CFG, 8'hc0);
      i_host.wr(tsa_pkg::ADDR_CFG, 8'h00);
      hi = 8'h20;
      lo = 8'hf6;
      i_host.wr(tsa_pkg::ADDR_HI_THR, hi);
      i_host.wr(tsa_pkg::ADDR_LO_THR, lo);
      i_host.wr(tsa_pkg::ADDR_IMASK, 8'h02);
      apply(hi, lo, 1'b0);
      chk({7'h00, irq}, 8'h00);
      apply(8'h00, lo - 8'h01, 1'b0);
      chk({7'h00, irq}, 8'h01);
      i_host.wr(tsa_pkg::ADDR_STAT, 8'h02);
      @(posedge mclk);
      #1 chk({7'h00, irq}, 8'h00);
      apply(8'h00, 8'h00, 1'b0);
      i_host.wr(tsa_pkg::ADDR_IMASK, 8'h00);
      apply(hi + 8'h01, 8'h00, 1'b0);
      chk({7'h00, irq}, 8'h00);
      repeat (12)
      begin
         rv = 8'($random(seed));
         i_host.wr(tsa_pkg::ADDR_CFG, {rv[0], 7'h00});
         apply(8'($random(seed)), 8'($random(seed)), rv[0]);
      end
      i_host.wr(tsa_pkg::ADDR_CFG, 8'h00);
      d = 8'($random(seed));
      apply(d, 8'h05, 1'b0);
      i_host.wr(tsa_pkg::ADDR_CFG, 8'h40);
      i_host.wr(tsa_pkg::ADDR_STAT, 8'h07);
      apply(d, 8'h05, 1'b0);
      chk({7'h00, standby}, 8'h01);
      rdchk(tsa_pkg::ADDR_STAT, 8'h00);
      @(posedge mclk);
      temps.diode <= 8'h11;
      settle();
      rdchk(tsa_pkg::ADDR_DIODE, d);
      // one-shot sent in standby only, never used to monitor while active
      i_host.wr(tsa_pkg::ADDR_CMD, 8'h00);
      settle();
      rdchk(tsa_pkg::ADDR_DIODE, 8'h11);
      chk({7'h00, standby}, 8'h01);
      rdchk(tsa_pkg::ADDR_STAT, 8'h05);
      @(posedge mclk);
      temps.diode <= 8'h22;
      settle();
      rdchk(tsa_pkg::ADDR_DIODE, 8'h11);
      wrap_up();
   end
endmodule
`default_nettype wire
